//--- tio_cfg.svh
// Constants for the timed I/O port: widths, reset values and clock block figures.
`ifndef TIO_CFG_SVH
`define TIO_CFG_SVH

// Width of the port counter and of every timestamp.
`define TIO_COUNT_W      16
// Reset value of the port counter.
`define TIO_COUNT_RST    16'h0000
// Number of clock blocks in the unit.
`define TIO_CLK_BLOCKS   6
// Clock block that every port uses after reset.
`define TIO_CLK_SEL_RST  3'h0
// Width of one clock block divider field.
`define TIO_DIV_W        8
// Rate of the tile reference clock followed by clock block 0, in MHz.
`define TIO_REF_MHZ      100
// Default port width in pins and default transfer word width in bits.
`define TIO_PORT_W       4
`define TIO_XFER_W       32

`endif

//--- tio_pkg.sv
// Types shared by the timed I/O port modules.
package tio_pkg;

   // Port sequencer states, one-hot.
   typedef enum logic [3:0] {
      TIO_IDLE = 4'b0001,
      TIO_WAIT = 4'b0010,
      TIO_RUN  = 4'b0100,
      TIO_HOLD = 4'b1000
   } tio_state_t;

   // Condition that a conditional input waits for.
   typedef enum logic [1:0] {
      TIO_COND_NONE = 2'h0,
      TIO_COND_EQ   = 2'h1,
      TIO_COND_NEQ  = 2'h2
   } tio_cond_t;

endpackage

//--- tio_buf2.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/10ps
`default_nettype none

module tio_buf2 #(
   parameter int WIDTH = 32
) (
   input  wire logic             sys_clk,
   input  wire logic             sys_rst,
   input  wire logic             in_valid,
   output var  logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output var  logic             out_valid,
   input  wire logic             out_ready,
   output var  logic [WIDTH-1:0] out_data
);

   logic [1:0]       fill;
   logic [WIDTH-1:0] spare;
   logic             push;
   logic             pop;
   logic [1:0]       next_fill;

   // Handshakes on both sides and the fill level they lead to.
   assign push = in_valid && in_ready;
   assign pop  = out_valid && out_ready;
   always_comb begin
      next_fill = fill;
      if (push && !pop) begin
         next_fill = fill + 2'h1;
      end else if (pop && !push) begin
         next_fill = fill - 2'h1;
      end
   end

   // Fill level and the registered flags derived from it.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         fill      <= 2'h0;
         in_ready  <= 1'b1;
         out_valid <= 1'b0;
      end else begin
         fill      <= next_fill;
         in_ready  <= (next_fill != 2'h2);
         out_valid <= (next_fill != 2'h0);
      end
   end

   // The head entry drives the output; the spare entry catches a word during a stall.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         out_data <= '0;
         spare    <= '0;
      end else begin
         if (pop) begin
            out_data <= (fill == 2'h2) ? spare : in_data;
         end else if (push && fill == 2'h0) begin
            out_data <= in_data;
         end
         if (push && (fill == 2'h2 || (fill == 2'h1 && !pop))) begin
            spare <= in_data;
         end
      end
   end

   // The buffer never claims a word it has no room for.
   chk_buf_nooverflow: assert property (@(posedge sys_clk) disable iff (sys_rst) fill != 2'h3)
      else $error("Buffer fill level out of range.");

endmodule

`default_nettype wire

//--- tio_port.sv
// Timed I/O port with serialiser, transfer register, port counter and six clock blocks.
`timescale 1ns/10ps
`default_nettype none
`include "tio_cfg.svh"

// How it works
// - Port width is a build parameter among one, four, eight, sixteen, thirty-two pins.
// - All pins of the port share one direction, input or output.
// - Port drives pins high or low, or samples them, optionally awaiting a condition.
// - A processor request is accepted at once only while the two-entry buffer has room.
// - Open-drain: a zero pulls the pin low, a one releases it; whole port.
// - Data passes through a shift register and a transfer register.
// - A sixteen-bit port counter sets the moment of each timed transfer.
// - The counter is always readable; a programmed value delays a transfer until match.
// - Each transfer captures the counter value as a timestamp.
// - An enabled link takes its shared pins away from the port.
// - Pins claimed by a narrower port are released; other pins stay usable.
// - The port always transfers at its full nominal width.
// - Six clock blocks; block 0 follows the reference clock, others programmable.
// - A clock block can run from a one-bit clock pin, optionally divided.
// - Peer strobe paces transfers; an outgoing strobe accompanies output data.
// - After reset the port is attached to clock block 0.
module tio_port #(
   parameter int W     = `TIO_PORT_W,
   parameter int TW    = `TIO_XFER_W,
   parameter int DIV_W = `TIO_DIV_W
) (
   input  wire logic                                   sys_clk,
   input  wire logic                                   sys_rst,
   input  wire logic                                   cfg_dir_out,
   input  wire logic                                   cfg_open_drain,
   input  wire logic                                   cfg_strobe_in,
   input  wire logic                                   cfg_strobe_out,
   input  wire tio_pkg::tio_cond_t                     cfg_cond_mode,
   input  wire logic [W-1:0]                           cfg_cond_value,
   input  wire logic                                   cfg_clk_wr,
   input  wire logic [2:0]                             cfg_clk_sel,
   input  wire logic [`TIO_CLK_BLOCKS-2:0]             cb_src_ext,
   input  wire logic [(`TIO_CLK_BLOCKS-1)*DIV_W-1:0]   cb_div,
   input  wire logic                                   link_enable,
   input  wire logic [W-1:0]                           link_pins,
   input  wire logic [W-1:0]                           narrow_pins,
   input  wire logic                                   time_valid,
   input  wire logic [`TIO_COUNT_W-1:0]                time_value,
   input  wire logic                                   tx_valid,
   output var  logic                                   tx_ready,
   input  wire logic [TW-1:0]                          tx_data,
   output var  logic                                   rx_valid,
   input  wire logic                                   rx_ready,
   output var  logic [TW-1:0]                          rx_data,
   output var  logic [`TIO_COUNT_W-1:0]                xfer_stamp,
   output var  logic [`TIO_COUNT_W-1:0]                port_count,
   output var  logic [2:0]                             port_clk_sel,
   output var  logic                                   cond_event,
   input  wire logic [W-1:0]                           pin_in,
   output var  logic [W-1:0]                           pin_out,
   output var  logic [W-1:0]                           pin_oe,
   input  wire logic                                   clk_pin,
   input  wire logic                                   strobe_from_peer,
   output var  logic                                   strobe_to_peer
);
   import tio_pkg::*;

   localparam int            NCB   = `TIO_CLK_BLOCKS;
   localparam int            BEATS = TW / W;
   localparam int            BW    = $clog2(BEATS + 1);
   localparam logic [2:0]    NSEL  = 3'(NCB);
   localparam logic [BW-1:0] BFULL = BW'(BEATS);

   // True when a sample satisfies the programmed condition.
   function automatic logic cond_met(input tio_cond_t mode, input logic [W-1:0] smp, input logic [W-1:0] val);
      case (mode)
         TIO_COND_EQ:  cond_met = (smp == val);
         TIO_COND_NEQ: cond_met = (smp != val);
         default:      cond_met = 1'b1;
      endcase
   endfunction

   logic [W-1:0]            pin_meta;
   logic [W-1:0]            pin_sync;
   logic                    peer_meta;
   logic                    peer_sync;
   logic                    ck_meta;
   logic                    ck_sync;
   logic                    ck_prev;
   logic                    ext_rise;
   logic [NCB-1:0]          cb_tick;
   logic                    port_tick;
   tio_state_t              st;
   tio_state_t              next_st;
   logic [TW-1:0]           shreg;
   logic [BW-1:0]           beats;
   logic [TW-1:0]           xfer_out;
   logic                    xfer_full;
   logic                    buf_valid;
   logic [TW-1:0]           buf_data;
   logic                    buf_pop;
   logic                    armed;
   logic [`TIO_COUNT_W-1:0] arm_time;
   logic [W-1:0]            pin_val;
   logic                    strobe_pend;
   logic [W-1:0]            taken;
   logic                    peer_ok;
   logic                    time_hit;
   logic                    data_ready;
   logic                    time_start;
   logic                    do_load;
   logic                    do_out_beat;
   logic                    do_in_beat;
   logic                    do_complete;
   logic                    last_beat;
   logic [TW-1:0]           in_shifted;
   logic                    first_beat;
   tio_cond_t               cond_used;
   logic [W-1:0]            cond_ref;

   // Widths outside the supported set cannot be built.
   initial begin
      chk_port_width: assert ((W == 1 || W == 4 || W == 8 || W == 16 || W == 32) && (TW % W == 0))
         else $error("Unsupported port or transfer width.");
   end

   // Pins, peer strobe and clock pin cross into the system clock through two flip-flops.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_meta  <= '0;
         pin_sync  <= '0;
         peer_meta <= 1'b0;
         peer_sync <= 1'b0;
         ck_meta   <= 1'b0;
         ck_sync   <= 1'b0;
         ck_prev   <= 1'b0;
      end else begin
         pin_meta  <= pin_in;
         pin_sync  <= pin_meta;
         peer_meta <= strobe_from_peer;
         peer_sync <= peer_meta;
         ck_meta   <= clk_pin;
         ck_sync   <= ck_meta;
         ck_prev   <= ck_sync;
      end
   end
   assign ext_rise = ck_sync && !ck_prev;

   // Block 0 ticks on every reference edge; the others divide the reference or the clock pin.
   assign cb_tick[0] = 1'b1;
   for (genvar k = 1; k < NCB; k++) begin : g_cb
      logic [DIV_W-1:0] cnt;
      logic             src;
      logic [DIV_W-1:0] div;
      assign src        = cb_src_ext[k-1] ? ext_rise : 1'b1;
      assign div        = cb_div[(k-1)*DIV_W +: DIV_W];
      assign cb_tick[k] = src && (cnt == div);
      always_ff @(posedge sys_clk or posedge sys_rst) begin
         if (sys_rst) begin
            cnt <= '0;
         end else if (src) begin
            cnt <= (cnt == div) ? '0 : cnt + 1'b1;
         end
      end
   end

   // Clock block selection; a write naming a missing block is ignored.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         port_clk_sel <= `TIO_CLK_SEL_RST;
      end else if (cfg_clk_wr && cfg_clk_sel < NSEL) begin
         port_clk_sel <= cfg_clk_sel;
      end
   end
   assign port_tick = cb_tick[port_clk_sel];

   // Free-running port counter, wrapping at its top value.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         port_count <= `TIO_COUNT_RST;
      end else if (port_tick) begin
         port_count <= port_count + 16'h0001;
      end
   end

   // Timed-transfer arm; a new time written in the cycle it is consumed still wins.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         armed    <= 1'b0;
         arm_time <= `TIO_COUNT_RST;
      end else begin
         if (time_start) begin
            armed <= 1'b0;
         end
         if (time_valid) begin
            armed    <= 1'b1;
            arm_time <= time_value;
         end
      end
   end

   // Words from the processor wait in a two-entry buffer, so a stalled peer loses none.
   tio_buf2 #(
      .WIDTH (TW)
   ) u_buf (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .in_valid  (tx_valid),
      .in_ready  (tx_ready),
      .in_data   (tx_data),
      .out_valid (buf_valid),
      .out_ready (!xfer_full),
      .out_data  (buf_data)
   );
   assign buf_pop = buf_valid && !xfer_full;

   // Sequencing terms for both directions.
   assign peer_ok     = !cfg_strobe_in || peer_sync;
   assign time_hit    = port_tick && (port_count == arm_time);
   assign data_ready  = cfg_dir_out ? xfer_full : 1'b1;
   assign time_start  = (st == TIO_WAIT) && time_hit && data_ready;
   assign last_beat   = (beats == {{(BW-1){1'b0}}, 1'b1});
   assign do_load     = cfg_dir_out && xfer_full && (((st == TIO_IDLE) && !armed) || time_start);
   assign do_out_beat = cfg_dir_out && (st == TIO_RUN) && port_tick && peer_ok;
   assign do_in_beat  = !cfg_dir_out && (st == TIO_RUN) && port_tick && peer_ok &&
                        ((beats != BFULL) || cond_met(cfg_cond_mode, pin_sync, cfg_cond_value));
   assign in_shifted  = (shreg >> W) | (TW'(pin_sync) << (TW - W));
   assign first_beat  = do_in_beat && (beats == BFULL);
   assign do_complete = !cfg_dir_out && ((do_in_beat && last_beat && (!rx_valid || rx_ready)) ||
                        ((st == TIO_HOLD) && !rx_valid));

   // Transfer register on the output side, filled from the buffer head.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         xfer_full <= 1'b0;
         xfer_out  <= '0;
      end else if (buf_pop) begin
         xfer_full <= 1'b1;
         xfer_out  <= buf_data;
      end else if (do_load) begin
         xfer_full <= 1'b0;
      end
   end

   // Next state of the port sequencer.
   always_comb begin
      next_st = st;
      case (st)
         TIO_IDLE: begin
            if (armed && data_ready) begin
               next_st = TIO_WAIT;
            end else if (do_load || (!cfg_dir_out && !armed)) begin
               next_st = TIO_RUN;
            end
         end
         TIO_WAIT: begin
            if (time_start) begin
               next_st = TIO_RUN;
            end
         end
         TIO_RUN: begin
            if (do_out_beat && last_beat) begin
               next_st = TIO_IDLE;
            end else if (do_in_beat && last_beat) begin
               next_st = do_complete ? TIO_IDLE : TIO_HOLD;
            end
         end
         TIO_HOLD: begin
            if (do_complete) begin
               next_st = TIO_IDLE;
            end
         end
         default: next_st = TIO_IDLE;
      endcase
   end

   // Sequencer state, shift register and beat count; one beat moves W bits, low bits first.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st    <= TIO_IDLE;
         shreg <= '0;
         beats <= '0;
      end else begin
         st <= next_st;
         if (next_st == TIO_RUN && st != TIO_RUN) begin
            beats <= BFULL;
         end else if (do_out_beat || do_in_beat) begin
            beats <= beats - 1'b1;
         end
         if (do_load) begin
            shreg <= xfer_out;
         end else if (do_out_beat) begin
            shreg <= shreg >> W;
         end else if (do_in_beat) begin
            shreg <= in_shifted;
         end
      end
   end

   // Condition in force at the first beat; a later change of mode must not relabel a word in flight.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cond_used <= TIO_COND_NONE;
         cond_ref  <= '0;
      end else if (first_beat) begin
         cond_used <= cfg_cond_mode;
         cond_ref  <= cfg_cond_value;
      end
   end

   // Input transfer register toward the processor; a completion wins over a take.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_valid   <= 1'b0;
         rx_data    <= '0;
         cond_event <= 1'b0;
      end else begin
         cond_event <= do_complete && ((first_beat ? cfg_cond_mode : cond_used) != TIO_COND_NONE);
         if (do_complete) begin
            rx_valid <= 1'b1;
            rx_data  <= (st == TIO_HOLD) ? shreg : in_shifted;
         end else if (rx_ready) begin
            rx_valid <= 1'b0;
         end
      end
   end

   // Timestamp of the moment data passes between pins and transfer register.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         xfer_stamp <= `TIO_COUNT_RST;
      end else if (do_load || do_complete) begin
         xfer_stamp <= port_count;
      end
   end

   // Pin drive: direction, open-drain, and pins lost to a link or a narrower port.
   assign taken = narrow_pins | (link_enable ? link_pins : '0);
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_val        <= '0;
         pin_out        <= '0;
         pin_oe         <= '0;
         strobe_pend    <= 1'b0;
         strobe_to_peer <= 1'b0;
      end else begin
         if (do_out_beat) begin
            pin_val <= shreg[W-1:0];
         end
         pin_out        <= cfg_open_drain ? '0 : pin_val;
         pin_oe         <= cfg_dir_out ? (~taken & (cfg_open_drain ? ~pin_val : '1)) : '0;
         strobe_pend    <= do_out_beat;
         strobe_to_peer <= cfg_strobe_out && strobe_pend;
      end
   end

   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   chk_dir_input: assert property (!cfg_dir_out |=> pin_oe == '0)
      else $error("Input port drives its pins.");
   chk_od_low_only: assert property (cfg_open_drain |=> pin_out == '0)
      else $error("Open-drain port drives a pin high.");
   chk_od_release: assert property (cfg_open_drain |=> (pin_oe & $past(pin_val)) == '0)
      else $error("Open-drain port drives a one.");
   chk_shared_pins: assert property (1'b1 |=> (pin_oe & $past(taken)) == '0)
      else $error("Port drives a pin owned by a link or narrower port.");
   chk_count_step: assert property (port_tick |=> port_count == 16'($past(port_count) + 16'h0001))
      else $error("Port counter did not advance by one.");
   chk_count_hold: assert property (!port_tick |=> $stable(port_count))
      else $error("Port counter moved without a tick.");
   chk_clk_default: assert property ($past(sys_rst) |-> port_clk_sel == 3'h0)
      else $error("Port not on clock block 0 after reset.");
   chk_stamp_take: assert property ($rose(rx_valid) |-> xfer_stamp == $past(port_count))
      else $error("Timestamp does not match counter at transfer.");
   chk_timed_start: assert property ($past(st) == TIO_WAIT && st == TIO_RUN |-> $past(port_count) == $past(arm_time))
      else $error("Timed transfer started off its time.");
   chk_event_cond: assert property (cond_event |-> rx_valid &&
         cond_met(cond_used, rx_data[W-1:0], cond_ref))
      else $error("Conditional event without a met condition.");
   chk_strobe_data: assert property (strobe_to_peer |-> $past(do_out_beat, 2) && $past(cfg_strobe_out))
      else $error("Outgoing strobe without a fresh output beat.");

   cov_out_word: cover property (do_load ##[1:200] (do_out_beat && last_beat));
   cov_cond_event: cover property (cond_event);
   cov_rx_hold: cover property (st == TIO_HOLD ##1 do_complete);
   cov_ext_clock: cover property (port_tick && port_clk_sel != 3'h0 && cb_src_ext != '0);

endmodule

`default_nettype wire

//--- tio_buf2_unused_guard.sv
// Holds no logic; it only switches implicit nets off and back on.
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

//--- tio_peer.sv
// Model of the external hardware wired to the port pins.
`timescale 1ns/10ps
`default_nettype none

module tio_peer (
   input  wire logic       sys_clk,
   input  wire logic       run_clk,
   input  wire logic [3:0] drive_val,
   input  wire logic       stall,
   output var  logic [3:0] pin_in,
   output var  logic       clk_pin,
   output var  logic       strobe_from_peer
);
   logic [2:0] cnt;

   // The application clock runs only on request and rests low between bursts.
   always_ff @(posedge sys_clk) begin
      cnt <= run_clk ? cnt + 3'h1 : 3'h0;
      clk_pin <= run_clk & cnt[2];
   end

   // Data is driven together with a ready strobe that drops while the peer stalls.
   assign pin_in = drive_val;
   assign strobe_from_peer = !stall;
endmodule

`default_nettype wire

//--- tb.sv
// Self-checking bench for the timed I/O port.
`timescale 1ns/10ps
`default_nettype none

module tb;
   import tio_pkg::*;
   logic        sys_clk = 1'h0;
   logic        sys_rst = 1'h1;
   logic        dir_out = 1'h1;
   logic        od = 1'h0;
   logic        clk_wr = 1'h0;
   logic        link_en = 1'h0;
   logic        tv = 1'h0;
   logic        txv = 1'h0;
   logic        rxr = 1'h0;
   logic        run_clk = 1'h0;
   logic        sin = 1'h0;
   logic        stall = 1'h0;
   tio_cond_t   cmode = TIO_COND_NONE;
   logic [3:0]  cval = 4'h0;
   logic [3:0]  lpins = 4'h0;
   logic [3:0]  narrow = 4'h0;
   logic [3:0]  drv = 4'h0;
   logic [2:0]  csel = 3'h0;
   logic [4:0]  src_ext = 5'h00;
   logic [39:0] div = 40'h0;
   logic [15:0] tval = 16'h0;
   logic [31:0] txd = 32'h0;
   logic        tx_ready, rx_valid, cev, clk_pin, sfp, stp;
   logic [3:0]  pin_in, pin_out, pin_oe;
   logic [2:0]  sel;
   logic [15:0] stamp, count, t0;
   logic [31:0] rxd;
   int          miscompares = 0;
   int          check_count = 0;
   int          guard = 0;
   int          cyc;

   tio_port dut (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .cfg_dir_out(dir_out), .cfg_open_drain(od),
      .cfg_strobe_in(sin), .cfg_strobe_out(1'h1), .cfg_cond_mode(cmode), .cfg_cond_value(cval),
      .cfg_clk_wr(clk_wr), .cfg_clk_sel(csel), .cb_src_ext(src_ext), .cb_div(div),
      .link_enable(link_en), .link_pins(lpins), .narrow_pins(narrow), .time_valid(tv),
      .time_value(tval), .tx_valid(txv), .tx_ready(tx_ready), .tx_data(txd), .rx_valid(rx_valid),
      .rx_ready(rxr), .rx_data(rxd), .xfer_stamp(stamp), .port_count(count), .port_clk_sel(sel),
      .cond_event(cev), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .clk_pin(clk_pin),
      .strobe_from_peer(sfp), .strobe_to_peer(stp)
   );

   tio_peer peer (
      .sys_clk(sys_clk), .run_clk(run_clk), .drive_val(drv), .stall(stall), .pin_in(pin_in),
      .clk_pin(clk_pin), .strobe_from_peer(sfp)
   );

   // A 50 ns clock.
   initial begin
      forever #25 sys_clk = ~sys_clk;
   end

   // Cuts a hung run short.
   always @(posedge sys_clk) begin
      guard++;
      if (guard == 20000) begin
         miscompares++;
         summarize();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   task automatic summarize;
      $display("checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // Hands one word over, then checks every beat at its outgoing strobe.
   task automatic send(input logic [31:0] w, input logic [3:0] keep);
      txv <= 1'h1;
      txd <= w;
      do @(posedge sys_clk); while (tx_ready !== 1'h1);
      txv <= 1'h0;
      for (int b = 0; b < 8; b++) begin
         cyc = 0;
         do begin
            @(posedge sys_clk);
            cyc++;
         end while (stp !== 1'h1 && cyc < 200);
         check({stp, pin_out, pin_oe}, {1'h1, od ? 4'h0 : w[4*b+:4], keep & (od ? ~w[4*b+:4] : 4'hf)});
      end
   endtask

   // Drops two stale words, then checks the third against the pin level.
   task automatic get(input logic ev);
      logic seen_ev;
      for (int k = 0; k < 3; k++) begin
         seen_ev = 1'h0;
         cyc = 0;
         do begin
            @(posedge sys_clk);
            cyc++;
            seen_ev |= cev;
         end while (rx_valid !== 1'h1 && cyc < 300);
         rxr <= 1'h1;
         tick(1);
         rxr <= 1'h0;
      end
      check({rx_valid, rxd, seen_ev}, {1'h1, {8{drv}}, ev});
   endtask

   task automatic wsel(input logic [2:0] s);
      csel <= s;
      clk_wr <= 1'h1;
      tick(1);
      clk_wr <= 1'h0;
      tick(2);
   endtask

   // Main sequence.
   initial begin
      tick(6);
      check({tx_ready, sel, count}, {1'h1, 3'h0, 16'h0});
      sys_rst <= 1'h0;
      tick(2);
      t0 = count;
      tick(5);
      check(count, t0 + 16'h5);
      send(32'h87654321, 4'hf);
      link_en <= 1'h1;
      lpins <= 4'h3;
      narrow <= 4'h4;
      send(32'h0f1e2d3c, 4'h8);
      od <= 1'h1;
      link_en <= 1'h0;
      narrow <= 4'h0;
      send(32'h9669a55a, 4'hf);
      t0 = count + 16'h3c;
      tval <= t0;
      tv <= 1'h1;
      tick(1);
      tv <= 1'h0;
      send(32'h12345678, 4'hf);
      check(stamp, t0);
      dir_out <= 1'h0;
      od <= 1'h0;
      drv <= 4'ha;
      get(1'h0);
      for (int i = 0; i < 2; i++) begin
         cmode <= i ? TIO_COND_NEQ : TIO_COND_EQ;
         cval <= 4'h5;
         drv <= i ? 4'h5 : 4'h3;
         repeat (2) begin
            rxr <= 1'h1;
            tick(1);
            rxr <= 1'h0;
            tick(40);
         end
         check(rx_valid, 1'h0);
         drv <= i ? 4'h6 : 4'h5;
         get(1'h1);
      end
      cmode <= TIO_COND_NONE;
      sin <= 1'h1;
      stall <= 1'h1;
      repeat (2) begin
         rxr <= 1'h1;
         tick(1);
         rxr <= 1'h0;
         tick(40);
      end
      check(rx_valid, 1'h0);
      stall <= 1'h0;
      get(1'h0);
      src_ext <= 5'h01;
      div <= 40'h01;
      wsel(3'h6);
      check(sel, 3'h0);
      wsel(3'h1);
      check(sel, 3'h1);
      t0 = count;
      tick(3);
      check(count, t0);
      run_clk <= 1'h1;
      tick(64);
      run_clk <= 1'h0;
      tick(6);
      check(count, t0 + 16'h4);
      summarize();
   end
endmodule

`default_nettype wire
